/* design/phy_ctl_pkg.sv */
/*
 * Package for the indicator override and transceiver control register bank.
 * Holds register offsets, field positions, reset values, timing counts and carrier types.
 * Assumes a 100 MHz device clock.
 */
package phy_ctl_pkg;
    // Register byte addresses, each register index times four
    localparam logic [7:0] LED_OVR_IDX    = 8'h18;
    localparam logic [7:0] MISC_CTL_IDX   = 8'h19;
    localparam logic [9:0] LED_OVR_ADDR   = {LED_OVR_IDX, 2'b00};
    localparam logic [9:0] MISC_CTL_ADDR  = {MISC_CTL_IDX, 2'b00};
    localparam logic [9:0] IRQ_STAT_ADDR  = 10'h080;
    localparam logic [9:0] IRQ_MASK_ADDR  = 10'h084;
    localparam logic [9:0] NEG_IN_ADDR    = 10'h088;
    localparam int ADDR_W = 10;

    // Indicator override fields
    localparam int SPD_OVR_EN_BIT = 5;
    localparam int LNK_OVR_EN_BIT = 4;
    localparam int ACT_OVR_EN_BIT = 3;
    localparam int SPD_VAL_BIT    = 2;
    localparam int LNK_VAL_BIT    = 1;
    localparam int ACT_VAL_BIT    = 0;
    localparam logic [15:0] LED_OVR_WMASK = 16'h003F;
    localparam logic [15:0] LED_OVR_RESET = 16'h0000;

    // Misc control fields
    localparam int AUTO_XOVER_BIT = 15;
    localparam int FORCE_XOVER_BIT = 14;
    localparam int PAUSE_RX_BIT   = 13;
    localparam int PAUSE_TX_BIT   = 12;
    localparam int INJ_ERR_BIT    = 11;
    localparam int LONG_SEQ_BIT   = 10;
    localparam int PASS_BIT       = 9;
    localparam int RUN_BIT        = 8;
    localparam int BYPASS_BIT     = 7;
    localparam int MODE_HI_BIT    = 6;
    localparam int MODE_LO_BIT    = 5;
    localparam int PAUSE_ADV_LO   = 10;

    // Interrupt status bits
    localparam int IRQ_FAIL_BIT   = 0;
    localparam int IRQ_PAUSE_BIT  = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // Indicator timing
    localparam int CLK_MHZ        = 100;
    localparam int STRETCH_MS     = 40;
    localparam int BLINK_MS       = 50;
    localparam int STRETCH_CYC    = STRETCH_MS * 1000 * CLK_MHZ;
    localparam int BLINK_CYC      = BLINK_MS * 1000 * CLK_MHZ;

    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Three indicator pins
    typedef struct packed {
        logic speed;
        logic link;
        logic act_col;
    } indicator_t;

    // Line state from the rest of the transceiver
    typedef struct packed {
        logic speed_100;
        logic link_good;
        logic activity;
        logic collision;
        logic full_duplex;
    } line_state_t;

    // Advertised pause bits of both ends
    typedef struct packed {
        logic [1:0] local_pause;
        logic [1:0] partner_pause;
        logic       hcd_full_duplex;
    } pause_adv_t;

    // Straps caught after reset release
    typedef struct packed {
        logic       auto_xover;
        logic       mode_lo;
        logic [4:0] port_address;
    } strap_t;

    // Controls toward the transceiver core
    typedef struct packed {
        logic auto_xover;
        logic forced_xover;
        logic selftest_run;
        logic long_seq;
        logic inject_error;
        logic [4:0] port_address;
    } core_ctl_t;
endpackage : phy_ctl_pkg

/* design/phy_led_mdix_bist_control.sv */
/*
 * Indicator override and transceiver control register bank with an AXI4-Lite slave.
 * Assumes line state, pause advertisement, self-test result and straps come from
 * other clock domains or pins and are synchronised here; the self-test engine sits outside.
 */
//
// Contract
// - Override register bits 15:6 ignore writes and read zero.
// - Speed override enable bit 5 drives bit 2 onto the speed pin.
// - Link override enable bit 4 drives bit 1 onto the link pin.
// - Activity override enable bit 3 drives bit 0 onto activity pin.
// - Override register reads return stored control values, never pin state.
// - Auto crossover enable bit 15 loads from strap, writable, gates detection.
// - Forced crossover bit 14 swaps transmit and receive pairs.
// - Bit 13 reports pause receive resolved, only for full-duplex result.
// - Bit 12 reports pause transmit resolved, only for full-duplex result.
// - Writing bit 11 injects exactly one error, then bit self-clears.
// - Bit 9 reads pass; a failure latches until self-test stops.
// - Bypass bit 7 drives indicators unstretched; zero keeps stretching.
// - Speed indicator is on at 100 Mb/s, off at 10 Mb/s.
// - In modes 0 and 2 link is steady on and blinks on activity.
`timescale 1ns/10ps
module phy_led_mdix_bist_control (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic                        clk_en,
    input  wire logic [9:0]                  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [9:0]                  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire phy_ctl_pkg::line_state_t    line_state,
    input  wire phy_ctl_pkg::pause_adv_t     pause_adv,
    input  wire phy_ctl_pkg::strap_t         strap,
    input  wire logic                        selftest_error,
    output phy_ctl_pkg::indicator_t          indicator,
    output phy_ctl_pkg::core_ctl_t           core_ctl,
    output logic                             irq
);
    import phy_ctl_pkg::*;

    typedef struct packed {
        logic              aw_hold;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_hold;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [5:0]        led_ovr;
        logic              auto_xover;
        logic              forced_xover;
        logic              inject_error;
        logic              long_seq;
        logic              pass;
        logic              run;
        logic              bypass;
        logic [1:0]        mode;
        logic [4:0]        port_address;
        logic              pause_rx;
        logic              pause_tx;
        logic [1:0]        irq_stat;
        logic [1:0]        irq_mask;
        logic              irq;
        logic [1:0]        strap_cnt;
        logic [31:0]       stretch_cnt;
        logic [31:0]       blink_cnt;
        logic              blink_phase;
        indicator_t        ind;
        line_state_t       line_s1;
        line_state_t       line_s2;
        pause_adv_t        adv_s1;
        pause_adv_t        adv_s2;
        strap_t            strap_s1;
        strap_t            strap_s2;
        logic              err_s1;
        logic              err_s2;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // Pause resolution of both advertised sym/asym pairs, returns {rx, tx}
    function automatic logic [1:0] pause_resolve(input pause_adv_t a);
        logic sym_l;
        logic asy_l;
        logic sym_p;
        logic asy_p;
        sym_l = a.local_pause[0];
        asy_l = a.local_pause[1];
        sym_p = a.partner_pause[0];
        asy_p = a.partner_pause[1];
        if (!a.hcd_full_duplex) begin
            pause_resolve = 2'h0;
        end else begin
            pause_resolve[1] = (sym_l & sym_p) | (sym_l & asy_l & ~sym_p & asy_p);
            pause_resolve[0] = (sym_l & sym_p) | (~sym_l & asy_l & sym_p & asy_p);
        end
    endfunction : pause_resolve

    // Register read view
    function automatic logic [31:0] reg_read(input state_t s, input logic [ADDR_W-1:0] a);
        reg_read = 32'h0000_0000;
        case (a)
            LED_OVR_ADDR:  reg_read[5:0] = s.led_ovr;
            MISC_CTL_ADDR: reg_read[15:0] = {s.auto_xover, s.forced_xover, s.pause_rx, s.pause_tx,
                                             s.inject_error, s.long_seq, s.pass, s.run, s.bypass,
                                             s.mode, s.port_address};
            IRQ_STAT_ADDR: reg_read[1:0] = s.irq_stat;
            IRQ_MASK_ADDR: reg_read[1:0] = s.irq_mask;
            NEG_IN_ADDR:   reg_read[PAUSE_ADV_LO+1:PAUSE_ADV_LO] = s.adv_s2.partner_pause;
            default:       reg_read = 32'h0000_0000;
        endcase
    endfunction : reg_read

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = (a == LED_OVR_ADDR) || (a == MISC_CTL_ADDR) || (a == IRQ_STAT_ADDR)
                  || (a == IRQ_MASK_ADDR) || (a == NEG_IN_ADDR);
    endfunction : addr_ok

    logic [15:0] wd;
    logic        wr_fire;
    logic        fail_evt;
    logic [1:0]  pres;
    logic        act_src;
    logic        lnk_src;
    logic        act_stretched;
    indicator_t  normal;

    // Next-state logic for bus, registers and indicators
    always_comb begin
        st_next  = st_reg;
        wd       = st_reg.w_data[15:0];
        wr_fire  = 1'b0;
        fail_evt = 1'b0;
        pres     = pause_resolve(st_reg.adv_s2);
        act_src  = 1'b0;
        lnk_src  = 1'b0;
        act_stretched = 1'b0;
        normal   = '0;

        // Input synchronisers
        st_next.line_s1  = line_state;
        st_next.line_s2  = st_reg.line_s1;
        st_next.adv_s1   = pause_adv;
        st_next.adv_s2   = st_reg.adv_s1;
        st_next.strap_s1 = strap;
        st_next.strap_s2 = st_reg.strap_s1;
        st_next.err_s1   = selftest_error;
        st_next.err_s2   = st_reg.err_s1;

        // Write channel capture, either order
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_hold = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
            st_next.awready = 1'b0;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_hold = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
            st_next.wready = 1'b0;
        end
        if (st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid) begin
            wr_fire        = 1'b1;
            st_next.aw_hold = 1'b0;
            st_next.w_hold  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = addr_ok(st_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid  = 1'b0;
            st_next.awready = 1'b1;
            st_next.wready  = 1'b1;
        end

        // Read channel
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.arready = 1'b0;
            st_next.rvalid  = 1'b1;
            st_next.rdata   = reg_read(st_reg, s_axi_araddr);
            st_next.rresp   = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid  = 1'b0;
            st_next.arready = 1'b1;
        end

        // Self-clearing error injection lasts one cycle
        st_next.inject_error = 1'b0;

        // Straps caught at the third enabled edge after release, once both sync stages hold them
        if (st_reg.strap_cnt != 2'h3) st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
        if (st_reg.strap_cnt == 2'h2) begin
            st_next.auto_xover   = st_reg.strap_s2.auto_xover;
            st_next.mode[0]      = st_reg.strap_s2.mode_lo;
            st_next.port_address = st_reg.strap_s2.port_address;
        end

        // Register writes, low two byte lanes hold the 16-bit registers
        if (wr_fire) begin
            case (st_reg.aw_addr)
                LED_OVR_ADDR: begin
                    if (st_reg.w_strb[0]) st_next.led_ovr = wd[5:0] & LED_OVR_WMASK[5:0];
                end
                MISC_CTL_ADDR: begin
                    if (st_reg.w_strb[1]) begin
                        st_next.auto_xover   = wd[AUTO_XOVER_BIT];
                        st_next.forced_xover = wd[FORCE_XOVER_BIT];
                        st_next.inject_error = wd[INJ_ERR_BIT];
                        st_next.long_seq     = wd[LONG_SEQ_BIT];
                        st_next.run          = wd[RUN_BIT];
                    end
                    if (st_reg.w_strb[0]) begin
                        st_next.bypass       = wd[BYPASS_BIT];
                        st_next.mode         = {wd[MODE_HI_BIT], wd[MODE_LO_BIT]};
                        st_next.port_address = wd[4:0];
                    end
                end
                IRQ_STAT_ADDR: begin
                    if (st_reg.w_strb[0]) st_next.irq_stat = st_reg.irq_stat & ~st_reg.w_data[1:0];
                end
                IRQ_MASK_ADDR: begin
                    if (st_reg.w_strb[0]) st_next.irq_mask = st_reg.w_data[1:0];
                end
                default: begin
                end
            endcase
        end

        // Pass flag: set when a run begins, latched clear on failure, cleared on stop
        if (!st_reg.run) begin
            st_next.pass = 1'b0;
        end else if (st_reg.err_s2) begin
            fail_evt     = st_reg.pass;
            st_next.pass = 1'b0;
        end
        if (st_next.run && !st_reg.run) st_next.pass = 1'b1;

        // Pause resolution only for full-duplex common mode
        st_next.pause_rx = pres[1];
        st_next.pause_tx = pres[0];

        // Sticky events, set wins over clear
        if (fail_evt) st_next.irq_stat[IRQ_FAIL_BIT] = 1'b1;
        if (pres != {st_reg.pause_rx, st_reg.pause_tx}) st_next.irq_stat[IRQ_PAUSE_BIT] = 1'b1;
        st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

        // Activity stretch and blink timers
        if (st_reg.line_s2.activity) begin
            st_next.stretch_cnt = STRETCH_CYC;
        end else if (st_reg.stretch_cnt != 32'h0) begin
            st_next.stretch_cnt = st_reg.stretch_cnt - 32'h1;
        end
        if (st_reg.blink_cnt == 32'h0) begin
            st_next.blink_cnt   = BLINK_CYC;
            st_next.blink_phase = ~st_reg.blink_phase;
        end else begin
            st_next.blink_cnt = st_reg.blink_cnt - 32'h1;
        end
        act_stretched = st_reg.bypass ? st_reg.line_s2.activity
                                      : (st_reg.line_s2.activity || st_reg.stretch_cnt != 32'h0);

        // Normal indication per mode
        normal.speed = st_reg.line_s2.speed_100;
        lnk_src      = st_reg.line_s2.link_good;
        if (st_reg.mode[0]) begin
            normal.link    = lnk_src;
            act_src        = act_stretched;
        end else begin
            normal.link    = lnk_src && !(act_stretched && st_reg.blink_phase);
            act_src        = st_reg.mode[1] ? st_reg.line_s2.full_duplex
                                            : st_reg.line_s2.collision;
        end
        normal.act_col = act_src;

        // Software override of each pin
        st_next.ind.speed   = st_reg.led_ovr[SPD_OVR_EN_BIT] ? st_reg.led_ovr[SPD_VAL_BIT]
                                                             : normal.speed;
        st_next.ind.link    = st_reg.led_ovr[LNK_OVR_EN_BIT] ? st_reg.led_ovr[LNK_VAL_BIT]
                                                             : normal.link;
        st_next.ind.act_col = st_reg.led_ovr[ACT_OVR_EN_BIT] ? st_reg.led_ovr[ACT_VAL_BIT]
                                                             : normal.act_col;
    end

    // State register with synchronous reset and clock enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg          <= '0;
            st_reg.awready  <= 1'b1;
            st_reg.wready   <= 1'b1;
            st_reg.arready  <= 1'b1;
            st_reg.led_ovr  <= LED_OVR_RESET[5:0];
            st_reg.irq_stat <= IRQ_RESET;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready  = st_reg.wready;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    assign indicator     = st_reg.ind;
    assign irq           = st_reg.irq;
    assign core_ctl      = '{auto_xover: st_reg.auto_xover, forced_xover: st_reg.forced_xover,
                             selftest_run: st_reg.run, long_seq: st_reg.long_seq,
                             inject_error: st_reg.inject_error, port_address: st_reg.port_address};

    // Checks
    sequence inj_written;
        wr_fire && st_reg.aw_addr == MISC_CTL_ADDR && st_reg.w_strb[1] && wd[INJ_ERR_BIT];
    endsequence
    AST_INJ_ONE_CYCLE: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        inj_written |=> core_ctl.inject_error ##1 !core_ctl.inject_error)
        else $error("error injection not a single cycle");
    AST_SPD_OVR: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        st_reg.led_ovr[SPD_OVR_EN_BIT] |=> indicator.speed == $past(st_reg.led_ovr[SPD_VAL_BIT]))
        else $error("speed override not applied");
    AST_LNK_OVR: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        st_reg.led_ovr[LNK_OVR_EN_BIT] |=> indicator.link == $past(st_reg.led_ovr[LNK_VAL_BIT]))
        else $error("link override not applied");
    AST_ACT_OVR: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        st_reg.led_ovr[ACT_OVR_EN_BIT] |=> indicator.act_col == $past(st_reg.led_ovr[ACT_VAL_BIT]))
        else $error("activity override not applied");
    AST_SPD_NORMAL: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        !st_reg.led_ovr[SPD_OVR_EN_BIT] |=> indicator.speed == $past(st_reg.line_s2.speed_100))
        else $error("speed indicator wrong");
    AST_LED_RSVD: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == LED_OVR_ADDR |=> s_axi_rdata[31:6] == 26'h0)
        else $error("override reserved bits not zero");
    AST_FAIL_LATCH: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        !st_reg.pass && st_reg.run && $past(st_reg.run) |=> !st_reg.pass)
        else $error("failure did not stay latched");
    AST_STOP_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        !st_reg.run |=> !st_reg.pass || st_reg.run)
        else $error("pass flag kept after stop");
    AST_PAUSE_HD: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        !st_reg.adv_s2.hcd_full_duplex |=> !st_reg.pause_rx && !st_reg.pause_tx)
        else $error("pause resolved in half duplex");
endmodule : phy_led_mdix_bist_control

/* sim/led_lamps.sv */
/*
 * Far-side model: three status lamps lit from the indicator pins.
 * Assumes pins are active high and the lamps hold no state of their own.
 */
`timescale 1ns/10ps
module led_lamps
    import phy_ctl_pkg::*;
(
    input  wire phy_ctl_pkg::indicator_t pins,
    output logic [2:0]                   lit
);
    // Each lamp glows while its pin is high; a lamp cannot report back to the bank
    assign lit = {pins.speed, pins.link, pins.act_col};
endmodule : led_lamps

/* sim/phy_led_mdix_bist_control_bench.sv */
/*
 * Self-checking bench for the indicator override and control register bank.
 * Assumes the package register map and an AXI4-Lite slave that may insert wait states.
 */
`timescale 1ns/10ps
module phy_led_mdix_bist_control_bench;
    import phy_ctl_pkg::*;
    logic aclk = 0, aresetn = 0, clk_en = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq, selftest_error = 0;
    logic [9:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp, bresp_seen;
    logic [3:0] wstrb = 4'hF;
    line_state_t line_state = '0;
    pause_adv_t pause_adv = '0;
    strap_t strap = '{1'b1, 1'b1, 5'h15};
    indicator_t indicator;
    core_ctl_t core_ctl;
    logic [2:0] lit;
    int n_fail = 0, num_checks = 0, n_inj = 0;
    logic [15:0] mtab [5] = '{16'h00A0, 16'h00A0, 16'h0080, 16'h00C0, 16'h00C0};
    logic [4:0] ltab [5] = '{5'b11100, 5'b01000, 5'b11010, 5'b01011, 5'b11010};
    logic [2:0] itab [5] = '{3'b111, 3'b010, 3'b111, 3'b011, 3'b110};

    phy_led_mdix_bist_control DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .line_state(line_state), .pause_adv(pause_adv), .strap(strap),
        .selftest_error(selftest_error), .indicator(indicator), .core_ctl(core_ctl), .irq(irq));
    led_lamps lamps (.pins(indicator), .lit(lit));

    // Clock and count of inject pulses toward the core
    always #5 aclk = ~aclk;
    always @(posedge aclk) if (core_ctl.inject_error === 1'b1) n_inj <= n_inj + 1;

    task automatic wrap_up;
        if (n_fail == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk

    // One write: address and data offered together, each released when taken
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        int i;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) begin
                bresp_seen = bresp;
                break;
            end
        end
        if (i == 50) begin
            n_fail++;
            wrap_up();
        end
    endtask : wr

    // One read, compared against expected data and response
    task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
        int i;
        logic [31:0] g;
        logic [1:0] r;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) begin
                g = rdata;
                r = rresp;
                break;
            end
        end
        if (i == 50) begin
            n_fail++;
            wrap_up();
        end
        chk(g, e);
        chk({30'h0, r}, {30'h0, er});
    endtask : rd

    // Main sequence; auto crossover stays off in every write since negotiation is never enabled
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        repeat (4) @(posedge aclk);
        rd(LED_OVR_ADDR, 32'h0, RESP_OKAY);
        rd(MISC_CTL_ADDR, 32'h8035, RESP_OKAY);
        chk({22'h0, core_ctl}, 32'h215);
        wr(LED_OVR_ADDR, 32'hFFFF);
        chk({30'h0, bresp_seen}, {30'h0, RESP_OKAY});
        repeat (3) @(posedge aclk);
        rd(LED_OVR_ADDR, 32'h3F, RESP_OKAY);
        chk({29'h0, lit}, 32'h7);
        wr(LED_OVR_ADDR, 32'h0007);
        repeat (3) @(posedge aclk);
        rd(LED_OVR_ADDR, 32'h07, RESP_OKAY);
        chk({29'h0, lit}, 32'h0);
        wr(MISC_CTL_ADDR, 32'h4D15);
        repeat (3) @(posedge aclk);
        rd(MISC_CTL_ADDR, 32'h4715, RESP_OKAY);
        chk({22'h0, core_ctl}, 32'h1D5);
        chk(n_inj, 32'h1);
        selftest_error <= 1;
        repeat (3) @(posedge aclk);
        selftest_error <= 0;
        repeat (6) @(posedge aclk);
        rd(MISC_CTL_ADDR, 32'h4515, RESP_OKAY);
        rd(IRQ_STAT_ADDR, 32'h1, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        wr(IRQ_MASK_ADDR, 32'h1);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(IRQ_STAT_ADDR, 32'h1);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rd(IRQ_STAT_ADDR, 32'h0, RESP_OKAY);
        wr(MISC_CTL_ADDR, 32'h4415);
        repeat (3) @(posedge aclk);
        rd(MISC_CTL_ADDR, 32'h4415, RESP_OKAY);
        pause_adv <= '{2'b01, 2'b01, 1'b1};
        repeat (6) @(posedge aclk);
        rd(MISC_CTL_ADDR, 32'h7415, RESP_OKAY);
        rd(NEG_IN_ADDR, 32'h400, RESP_OKAY);
        pause_adv.hcd_full_duplex <= 1'b0;
        repeat (6) @(posedge aclk);
        rd(MISC_CTL_ADDR, 32'h4415, RESP_OKAY);
        rd(IRQ_STAT_ADDR, 32'h2, RESP_OKAY);
        rd(10'h100, 32'h0, RESP_SLVERR);
        wr(10'h100, 32'h0);
        chk({30'h0, bresp_seen}, {30'h0, RESP_SLVERR});
        // Only byte lane 1 enabled: crossover and self-test fields clear, low byte stays
        wstrb <= 4'h2;
        wr(MISC_CTL_ADDR, 32'h0000);
        wstrb <= 4'hF;
        rd(MISC_CTL_ADDR, 32'h0015, RESP_OKAY);
        chk({22'h0, core_ctl}, 32'h015);
        // Display modes with stretching bypassed so levels show at once
        for (int k = 0; k < 5; k++) begin
            wr(MISC_CTL_ADDR, {16'h0, mtab[k]});
            line_state <= line_state_t'(ltab[k]);
            repeat (6) @(posedge aclk);
            chk({29'h0, lit}, {29'h0, itab[k]});
        end
        // Clock enable low freezes the indicators although the line state moves
        clk_en <= 0;
        line_state <= '0;
        repeat (6) @(posedge aclk);
        chk({29'h0, lit}, {29'h0, itab[4]});
        clk_en <= 1;
        // Stretching back on: the earlier activity burst still lights the activity pin
        wr(MISC_CTL_ADDR, 32'h0020);
        repeat (6) @(posedge aclk);
        chk({29'h0, lit}, 32'h1);
        wrap_up();
    end
endmodule : phy_led_mdix_bist_control_bench
